/* File: core/rescue_map.svh */
// timing and sequence constants of the power-loss rescue link
`ifndef RESCUE_MAP_SVH
`define RESCUE_MAP_SVH

`define CLK_FREQ_HZ 200000000
`define CLK_FREQ_MHZ 200

`define DESELECT_MIN_TIME_NS 50
`define DESELECT_MIN_CYC ((`DESELECT_MIN_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RESET_PULSE_MIN_NS 50
`define RESET_PULSE_MIN_CYC ((`RESET_PULSE_MIN_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RESET_RECOVERY_SHORT_NS 40
`define RESET_RECOVERY_SHORT_CYC ((`RESET_RECOVERY_SHORT_NS * `CLK_FREQ_MHZ) / 1000)
`define RESET_RECOVERY_ARRAY_US 30
`define RESET_RECOVERY_ARRAY_CYC (`RESET_RECOVERY_ARRAY_US * `CLK_FREQ_MHZ)
`define POWER_TO_FULL_ACCESS_TIME_US 150
`define POWER_TO_FULL_ACCESS_CYC (`POWER_TO_FULL_ACCESS_TIME_US * `CLK_FREQ_MHZ)
`define STATUS_WRITE_CYCLE_TIME_MS 8
`define STATUS_WRITE_CYC (`STATUS_WRITE_CYCLE_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define NV_CONFIG_WRITE_CYCLE_TIME_S 3
`define NV_CONFIG_WRITE_CYC (`NV_CONFIG_WRITE_CYCLE_TIME_S * `CLK_FREQ_HZ)

`define SCLK_DIV 6

`define STEP_QUAD_CLKS 5'h07
`define STEP_DUAL_CLKS 5'h0D
`define STEP_EXT_CLKS 5'h19
`define STEP_FF_CLKS 5'h08
`define STEP_LAST 2'h3

`define CONFIRM_QUAD_CLK 5'h07
`define CONFIRM_DUAL_CLK 5'h0D
`define CONFIRM_EXT_CLK 5'h19
`define CMD_BITS 5'h08
`define CNT_MAX 5'h1F

`endif

/* File: core/rescue_pkg.sv */
// types shared by both ends of the rescue link
package rescue_pkg;
  typedef enum logic [1:0] {
    PROTO_EXT = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } protocol_type;

  // what the flash was doing when its reset pin fell
  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_ARRAY = 2'h1,
    OP_STATUS_WRITE = 2'h2,
    OP_NV_CONFIG_WRITE = 2'h3
  } op_kind_type;

  typedef enum logic [5:0] {
    H_POWER = 6'h01,
    H_IDLE = 6'h02,
    H_FRAME = 6'h04,
    H_GAP = 6'h08,
    H_RSTLOW = 6'h10,
    H_RSTWAIT = 6'h20
  } host_state_type;

  typedef enum logic [3:0] {
    D_POWER = 4'h1,
    D_HELD = 4'h2,
    D_RECOVER = 4'h4,
    D_READY = 4'h8
  } dev_state_type;
endpackage

/* File: core/rescue_if.sv */
// serial flash link between the rescue host and the flash end
`timescale 1ns/100ps
interface rescue_if;
  logic sclk;
  logic csN;
  logic dq0HostOut;
  logic dq0HostOe;
  logic dq0DevOut;
  logic dq0DevOe;
  logic serialDataLine0;
  logic holdDataLine3;
  logic resetN;

  // pull-up when nobody drives the data line
  assign serialDataLine0 = dq0HostOe ? dq0HostOut : (dq0DevOe ? dq0DevOut : 1'b1);

  modport host (
    output sclk,
    output csN,
    output dq0HostOut,
    output dq0HostOe,
    output holdDataLine3,
    output resetN,
    input serialDataLine0
  );

  modport flash (
    input sclk,
    input csN,
    input serialDataLine0,
    input holdDataLine3,
    input resetN,
    output dq0DevOut,
    output dq0DevOe
  );
endinterface

/* File: core/rescue_flash.sv */
// flash end: frame decoding on the link clock, reset and readiness on mclk
`timescale 1ns/100ps
`include "rescue_map.svh"
module rescue_flash #(
  parameter int unsigned ARRAY_RECOVERY_CYC = `RESET_RECOVERY_ARRAY_CYC,
  parameter int unsigned POWER_UP_CYC = `POWER_TO_FULL_ACCESS_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  rescue_if.flash link,
  input wire rescue_pkg::protocol_type nvProtocol,
  input wire logic nvXip,
  input wire rescue_pkg::op_kind_type opKind,
  output logic deviceReady,
  output logic xipActive,
  output rescue_pkg::protocol_type protocol,
  output logic cmdValid,
  output logic [7:0] cmdCode
);
  // link clock domain
  logic fresh;
  logic [4:0] clkCnt;
  logic allOnes;
  logic confirmBit;
  logic [7:0] shiftReg;
  logic [4:0] confirmClk;

  // mode bits change only while deselected, so they are static during a frame
  always_comb begin
    case (protocol)
      rescue_pkg::PROTO_QUAD: confirmClk = `CONFIRM_QUAD_CLK;
      rescue_pkg::PROTO_DUAL: confirmClk = `CONFIRM_DUAL_CLK;
      default: confirmClk = `CONFIRM_EXT_CLK;
    endcase
  end

  // marks the first clock of a frame; chip select high rearms it
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_ff @(posedge link.sclk or negedge rstn) begin
    if (!rstn) begin
      clkCnt <= 5'h00;
      allOnes <= 1'b0;
      confirmBit <= 1'b0;
      shiftReg <= 8'h00;
    end else if (fresh) begin
      clkCnt <= 5'h01;
      allOnes <= link.serialDataLine0 & link.holdDataLine3;
      confirmBit <= (confirmClk == 5'h01) & link.serialDataLine0;
      shiftReg <= {7'h00, link.serialDataLine0};
    end else begin
      if (clkCnt != `CNT_MAX) begin
        clkCnt <= clkCnt + 5'h01;
      end
      allOnes <= allOnes & link.serialDataLine0 & link.holdDataLine3;
      if (clkCnt + 5'h01 == confirmClk) begin
        confirmBit <= link.serialDataLine0; // [RULE_15]
      end
      if (clkCnt < `CMD_BITS) begin
        shiftReg <= {shiftReg[6:0], link.serialDataLine0};
      end
    end
  end

  assign link.dq0DevOut = 1'b0;
  assign link.dq0DevOe = 1'b0;

  // mclk domain
  logic csMeta;
  logic csSync;
  logic csPrev;
  logic rpMeta;
  logic rpSync;
  logic csRise;
  logic [31:0] timer;
  logic [31:0] lowCnt;
  logic pulseOk;
  rescue_pkg::dev_state_type state;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csPrev <= 1'b1;
      rpMeta <= 1'b1;
      rpSync <= 1'b1;
    end else begin
      csMeta <= link.csN;
      csSync <= csMeta;
      csPrev <= csSync;
      rpMeta <= link.resetN;
      rpSync <= rpMeta;
    end
  end

  assign csRise = csSync & ~csPrev;
  assign pulseOk = (lowCnt >= 32'(`RESET_PULSE_MIN_CYC - 1)) & ~rpSync;

  // reset pin low time; a shorter pulse than the minimum is ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= 32'h0000_0000;
    end else if (rpSync) begin
      lowCnt <= 32'h0000_0000;
    end else if (!pulseOk) begin
      lowCnt <= lowCnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= rescue_pkg::D_POWER;
      timer <= 32'h0000_0000;
    end else if (pulseOk) begin
      state <= rescue_pkg::D_HELD;
      timer <= 32'h0000_0000;
    end else begin
      case (state)
        rescue_pkg::D_POWER: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= POWER_UP_CYC - 1) begin
            state <= rescue_pkg::D_READY; // [RULE_14]
          end
        end
        rescue_pkg::D_HELD: begin
          if (rpSync) begin
            if (opKind == rescue_pkg::OP_IDLE) begin
              state <= rescue_pkg::D_READY; // [RULE_11]
            end else begin
              state <= rescue_pkg::D_RECOVER;
            end
          end
        end
        rescue_pkg::D_RECOVER: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= ARRAY_RECOVERY_CYC - 1) begin
            state <= rescue_pkg::D_READY; // [RULE_12]
          end
        end
        rescue_pkg::D_READY: begin
          timer <= 32'h0000_0000;
        end
        default: begin
          state <= rescue_pkg::D_POWER;
          timer <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign deviceReady = (state == rescue_pkg::D_READY);

  // modes: loaded from the nonvolatile setting while not ready, edited at frame end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      xipActive <= 1'b0;
      protocol <= rescue_pkg::PROTO_EXT;
    end else if (state != rescue_pkg::D_READY) begin
      xipActive <= nvXip;
      protocol <= nvProtocol;
    end else if (csRise) begin
      if (xipActive) begin
        if (clkCnt >= confirmClk && confirmBit) begin
          xipActive <= 1'b0; // [RULE_15] [RULE_16]
        end
      end else if (protocol != rescue_pkg::PROTO_EXT && clkCnt == `STEP_FF_CLKS && allOnes) begin
        protocol <= rescue_pkg::PROTO_EXT; // [RULE_08]
      end
    end
  end

  // ordinary command codes are taken in extended single-line mode only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmdValid <= 1'b0;
      cmdCode <= 8'h00;
    end else begin
      cmdValid <= 1'b0;
      if (deviceReady && csRise && !xipActive && protocol == rescue_pkg::PROTO_EXT && clkCnt >= `CMD_BITS) begin
        cmdValid <= 1'b1; // [RULE_08]
        cmdCode <= shiftReg;
      end
    end
  end
endmodule

/* File: core/rescue_host.sv */
// host end: power-up wait, rescue frames and reset pin pulses on mclk
`timescale 1ns/100ps
`include "rescue_map.svh"
// Behaviour
// RULE_01 - after failed config write, run rescue
// RULE_02 - part one fully before part two
// RULE_03 - chip select high at least 50 ns
// RULE_04 - step one: seven clocks, ones held
// RULE_05 - step two: thirteen clocks, ones held
// RULE_06 - step three: twenty-five clocks, ones held
// RULE_07 - part two: eight clocks of ones
// RULE_08 - device then runs extended single-line protocol
// RULE_09 - afterwards rewrite the nonvolatile configuration
// RULE_10 - reset pin low at least 50 ns
// RULE_11 - short states ready 40 ns after reset
// RULE_12 - program or erase states ready 30 us
// RULE_13 - wait full write time after interrupted write
// RULE_14 - 150 us from power to access
// RULE_15 - confirmation one ends execute-in-place
// RULE_16 - confirmation one aborts nothing, resets nothing
// RULE_17 - steps ordered seven, thirteen, twenty-five
module rescue_host #(
  parameter int unsigned SCLK_DIV = `SCLK_DIV,
  parameter int unsigned POWER_UP_CYC = `POWER_TO_FULL_ACCESS_CYC,
  parameter int unsigned ARRAY_RECOVERY_CYC = `RESET_RECOVERY_ARRAY_CYC,
  parameter int unsigned STATUS_WRITE_CYC = `STATUS_WRITE_CYC,
  parameter int unsigned NV_CONFIG_WRITE_CYC = `NV_CONFIG_WRITE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  rescue_if.host link,
  input wire logic rescueStart,
  input wire logic resetStart,
  input wire rescue_pkg::op_kind_type resetCause,
  output logic busy,
  output logic poweredUp,
  output logic rescueDone,
  output logic rewriteNvHint
);
  // sclk rises when divCnt reaches HALF - 1 and falls at the wrap; an odd divider gives a longer high phase
  localparam int unsigned HALF = SCLK_DIV / 2;

  rescue_pkg::host_state_type state;
  logic [31:0] timer;
  logic [31:0] waitCyc;
  logic [7:0] divCnt;
  logic [4:0] edges;
  logic [1:0] step;
  logic [4:0] stepLen;
  logic lastEdge;
  logic edgeNow;

  // part one quad, dual, extended in turn, then the all-ones byte
  always_comb begin
    case (step)
      2'h0: stepLen = `STEP_QUAD_CLKS; // [RULE_04] [RULE_17]
      2'h1: stepLen = `STEP_DUAL_CLKS; // [RULE_05] [RULE_17]
      2'h2: stepLen = `STEP_EXT_CLKS; // [RULE_06] [RULE_17]
      default: stepLen = `STEP_FF_CLKS; // [RULE_07] [RULE_02]
    endcase
  end

  // wait after the reset pin rises depends on what the flash was doing
  always_comb begin
    case (resetCause)
      rescue_pkg::OP_ARRAY: waitCyc = ARRAY_RECOVERY_CYC; // [RULE_12]
      rescue_pkg::OP_STATUS_WRITE: waitCyc = STATUS_WRITE_CYC; // [RULE_13]
      rescue_pkg::OP_NV_CONFIG_WRITE: waitCyc = NV_CONFIG_WRITE_CYC; // [RULE_13]
      default: waitCyc = 32'(`RESET_RECOVERY_SHORT_CYC); // [RULE_11]
    endcase
  end

  // edgeNow marks the cycle that launches a rising link clock edge
  assign edgeNow = (state == rescue_pkg::H_FRAME) && (divCnt == 8'(HALF - 1));
  assign lastEdge = (edges == stepLen);

  // sequencer
  // recovery wait latched with the request, so a later change of the cause has no effect
  logic [31:0] rstWait;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= rescue_pkg::H_POWER;
      timer <= 32'h0000_0000;
      step <= 2'h0;
      rstWait <= 32'h0000_0000;
    end else begin
      case (state)
        rescue_pkg::H_POWER: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= POWER_UP_CYC - 1) begin
            state <= rescue_pkg::H_IDLE; // [RULE_14]
            timer <= 32'h0000_0000;
          end
        end
        rescue_pkg::H_IDLE: begin
          timer <= 32'h0000_0000;
          // a reset pin request wins over a rescue request in the same cycle
          if (resetStart) begin
            state <= rescue_pkg::H_RSTLOW;
            rstWait <= waitCyc;
          end else if (rescueStart) begin
            state <= rescue_pkg::H_FRAME; // [RULE_01]
            step <= 2'h0;
          end
        end
        rescue_pkg::H_FRAME: begin
          if (edgeNow && lastEdge) begin
            state <= rescue_pkg::H_GAP;
            timer <= 32'h0000_0000;
          end
        end
        rescue_pkg::H_GAP: begin
          // the registered select falls one cycle late, so the gap on the pin exceeds the count
          timer <= timer + 32'h0000_0001;
          if (timer >= 32'(`DESELECT_MIN_CYC - 1)) begin
            timer <= 32'h0000_0000;
            if (step == `STEP_LAST) begin
              state <= rescue_pkg::H_IDLE;
            end else begin
              state <= rescue_pkg::H_FRAME; // [RULE_03]
              step <= step + 2'h1;
            end
          end
        end
        rescue_pkg::H_RSTLOW: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= 32'(`RESET_PULSE_MIN_CYC - 1)) begin
            state <= rescue_pkg::H_RSTWAIT; // [RULE_10]
            timer <= 32'h0000_0000;
          end
        end
        rescue_pkg::H_RSTWAIT: begin
          // no selection until the flash has finished what the pulse cut short
          timer <= timer + 32'h0000_0001;
          if (timer >= rstWait - 1) begin
            state <= rescue_pkg::H_IDLE; // [RULE_13]
            timer <= 32'h0000_0000;
          end
        end
        default: begin
          state <= rescue_pkg::H_POWER;
          timer <= 32'h0000_0000;
        end
      endcase
    end
  end

  // link clock divider: low half first so data is set up before each rising edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 8'h00;
      edges <= 5'h00;
    end else if (state != rescue_pkg::H_FRAME || (edgeNow && lastEdge)) begin
      divCnt <= 8'h00;
      edges <= 5'h00;
    end else begin
      if (divCnt == 8'(SCLK_DIV - 1)) begin
        divCnt <= 8'h00;
      end else begin
        divCnt <= divCnt + 8'h01;
      end
      if (edgeNow) begin
        edges <= edges + 5'h01;
      end
    end
  end

  // pins: select dropped and line zero driven high for the whole frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.sclk <= 1'b0;
      link.csN <= 1'b1;
      link.dq0HostOut <= 1'b1;
      link.dq0HostOe <= 1'b0;
      link.resetN <= 1'b1;
    end else begin
      // chip select rises instead of the clock that would be one too many
      link.sclk <= (state == rescue_pkg::H_FRAME) && !(edgeNow && lastEdge)
        && ((divCnt >= 8'(HALF - 1)) && (divCnt != 8'(SCLK_DIV - 1))); // [RULE_04] [RULE_05] [RULE_06] [RULE_07]
      link.csN <= !((state == rescue_pkg::H_FRAME) && !(edgeNow && lastEdge));
      link.dq0HostOut <= 1'b1;
      link.dq0HostOe <= (state == rescue_pkg::H_FRAME);
      link.resetN <= !((state == rescue_pkg::H_IDLE && resetStart) || state == rescue_pkg::H_RSTLOW); // [RULE_10]
    end
  end

  // the rescue needs ones on line three as well, and nothing here ever pauses a transfer
  assign link.holdDataLine3 = 1'b1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rescueDone <= 1'b0;
      rewriteNvHint <= 1'b0;
    end else begin
      // done pulses as the last gap runs out; the hint then stands until the next rescue
      rescueDone <= (state == rescue_pkg::H_GAP) && (step == `STEP_LAST)
        && (timer >= 32'(`DESELECT_MIN_CYC - 1)); // [RULE_02]
      if (rescueDone) begin
        rewriteNvHint <= 1'b1; // [RULE_09]
      end else if (rescueStart && state == rescue_pkg::H_IDLE) begin
        rewriteNvHint <= 1'b0;
      end
    end
  end

  // busy also covers the power wait, so no start is taken before the flash can answer
  assign busy = (state != rescue_pkg::H_IDLE);
  assign poweredUp = (state != rescue_pkg::H_POWER);
endmodule

/* File: test/rescue_assertions.sv */
// concurrent checks on the rescue link wires
`timescale 1ns/100ps
`include "rescue_map.svh"
module rescue_assertions #(
  parameter int unsigned POWER_UP_CYC = 50
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic dq0HostOe,
  input wire logic serialDataLine0,
  input wire logic holdDataLine3,
  input wire logic resetN
);
  logic [7:0] highCnt;
  logic [5:0] frameCnt;
  logic [5:0] lastLen;
  logic [15:0] sinceRst;
  logic sclkQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // consecutive deselected cycles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) highCnt <= 8'h00;
    else if (!csN) highCnt <= 8'h00;
    else if (highCnt != 8'hFF) highCnt <= highCnt + 8'h01;
  end
  // link clock rises inside the current frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclkQ <= 1'b0;
      frameCnt <= 6'h00;
    end else begin
      sclkQ <= sclk;
      if (csN) frameCnt <= 6'h00;
      else if (sclk && !sclkQ) frameCnt <= frameCnt + 6'h01;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lastLen <= 6'h00;
    else if ($rose(csN)) lastLen <= frameCnt;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) sinceRst <= 16'h0000;
    else if (sinceRst != 16'hFFFF) sinceRst <= sinceRst + 16'h0001;
  end

  property p_deselect_gap;
    $fell(csN) |-> highCnt >= `DESELECT_MIN_CYC;
  endproperty
  a_deselect_gap: assert property (p_deselect_gap) else $error("chip select high too short");
  property p_reset_pulse;
    $fell(resetN) |-> (!resetN)[*8] ##1 !resetN ##1 !resetN;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pin pulse too short");
  property p_ones_on_rise;
    (!csN && $rose(sclk)) |-> serialDataLine0 && holdDataLine3;
  endproperty
  a_ones_on_rise: assert property (p_ones_on_rise) else $error("data or hold low at clock");
  property p_frame_length;
    $rose(csN) |-> frameCnt inside {6'h07, 6'h0D, 6'h19, 6'h08};
  endproperty
  a_frame_length: assert property (p_frame_length) else $error("frame clock count wrong");
  property p_step_order;
    ($rose(csN) && frameCnt inside {6'h0D, 6'h19}) |-> lastLen == ((frameCnt == 6'h0D) ? 6'h07 : 6'h0D);
  endproperty
  a_step_order: assert property (p_step_order) else $error("part one steps out of order");
  property p_part_order;
    ($rose(csN) && frameCnt inside {6'h07, 6'h08}) |-> ((frameCnt == 6'h08) ? lastLen == 6'h19 : lastLen inside {6'h00, 6'h08});
  endproperty
  a_part_order: assert property (p_part_order) else $error("part two not after part one");
  property p_clock_idle;
    csN |-> !sclk;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("link clock high while deselected");
  property p_drive_in_frame;
    !csN |-> dq0HostOe;
  endproperty
  a_drive_in_frame: assert property (p_drive_in_frame) else $error("data line undriven in frame");
  property p_frame_ends;
    $fell(csN) |-> ##[1:200] csN;
  endproperty
  a_frame_ends: assert property (p_frame_ends) else $error("frame never ends");
  property p_power_wait;
    ($fell(csN) || $fell(resetN)) |-> sinceRst >= POWER_UP_CYC;
  endproperty
  a_power_wait: assert property (p_power_wait) else $error("access before power wait");

  cover property ($rose(csN) && frameCnt == 6'h19);
  cover property ($rose(csN) && frameCnt == 6'h08 && lastLen == 6'h19);
  cover property ($rose(resetN));
endmodule

/* File: test/flash_power_loss_rescue_bench.sv */
// self-checking bench joining the rescue host and the flash end
`timescale 1ns/100ps
module flash_power_loss_rescue_bench;
  localparam int PUC = 50;
  localparam int ARR = 40;
  localparam int STW = 60;
  localparam int NVW = 80;
  localparam int DIV = 6;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic rescueStart = 1'b0;
  logic resetStart = 1'b0;
  rescue_pkg::op_kind_type resetCause = rescue_pkg::OP_IDLE;
  rescue_pkg::op_kind_type opKind = rescue_pkg::OP_IDLE;
  rescue_pkg::protocol_type nvProtocol = rescue_pkg::PROTO_EXT;
  rescue_pkg::protocol_type protocol;
  logic nvXip = 1'b0;
  logic busy, poweredUp, rescueDone, rewriteNvHint, deviceReady, xipActive, cmdValid;
  logic [7:0] cmdCode;
  logic [31:0] seed = 32'h0000_0013;
  int nMismatch = 0;
  int nChecks = 0;
  int frames[$];
  int clkCnt = 0;
  int onesBad = 0;
  logic cmdSeen = 1'b0;
  logic sclkQ = 1'b0;
  logic csNQ = 1'b1;

  rescue_if rif();
  always #2.5 mclk = ~mclk;

  rescue_host #(.SCLK_DIV(DIV), .POWER_UP_CYC(PUC), .ARRAY_RECOVERY_CYC(ARR), .STATUS_WRITE_CYC(STW),
    .NV_CONFIG_WRITE_CYC(NVW)) rescue_host_i (.mclk(mclk), .rstn(rstn), .link(rif.host),
    .rescueStart(rescueStart), .resetStart(resetStart), .resetCause(resetCause), .busy(busy),
    .poweredUp(poweredUp), .rescueDone(rescueDone), .rewriteNvHint(rewriteNvHint));
  rescue_flash #(.ARRAY_RECOVERY_CYC(ARR), .POWER_UP_CYC(PUC)) rescue_flash_i (.mclk(mclk), .rstn(rstn),
    .link(rif.flash), .nvProtocol(nvProtocol), .nvXip(nvXip), .opKind(opKind), .deviceReady(deviceReady),
    .xipActive(xipActive), .protocol(protocol), .cmdValid(cmdValid), .cmdCode(cmdCode));
  rescue_assertions #(.POWER_UP_CYC(PUC)) rescue_assertions_i (.mclk(mclk), .rstn(rstn), .sclk(rif.sclk),
    .csN(rif.csN), .dq0HostOe(rif.dq0HostOe), .serialDataLine0(rif.serialDataLine0),
    .holdDataLine3(rif.holdDataLine3), .resetN(rif.resetN));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int frame_len(input int i);
    return (i == 0) ? 7 : (i == 1) ? 13 : (i == 2) ? 25 : 8;
  endfunction
  // every frame with its leading low half, and the 50 ns deselect gap after it
  function automatic int rescue_cycles();
    int s = 0;
    for (int i = 0; i < 4; i++) s += frame_len(i) * DIV + DIV / 2 + 10;
    return s;
  endfunction
  function automatic int host_wait(input rescue_pkg::op_kind_type c);
    case (c)
      rescue_pkg::OP_IDLE: return 8;
      rescue_pkg::OP_ARRAY: return ARR;
      rescue_pkg::OP_STATUS_WRITE: return STW;
      default: return NVW;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watches the wire: clocks per frame, ones on the lines, commands seen
  always @(posedge mclk) begin
    if (rif.csN === 1'b0 && rif.sclk === 1'b1 && sclkQ === 1'b0) begin
      clkCnt++;
      if (rif.serialDataLine0 !== 1'b1 || rif.holdDataLine3 !== 1'b1) onesBad++;
    end
    if (rif.csN === 1'b1 && csNQ === 1'b0) begin
      frames.push_back(clkCnt);
      clkCnt = 0;
    end
    if (cmdValid === 1'b1) begin
      cmdSeen = 1'b1;
      chk("command code", 32'h0000_00FF, cmdCode);
    end
    sclkQ = rif.sclk;
    csNQ = rif.csN;
  end

  task automatic pulse_reset(input rescue_pkg::op_kind_type c);
    int lo = 0;
    int r = -1;
    int b = -1;
    int k = 0;
    logic dn = 1'b0;
    @(posedge mclk);
    resetStart <= 1'b1;
    resetCause <= c;
    opKind <= c;
    @(posedge mclk);
    resetStart <= 1'b0;
    while (rif.resetN !== 1'b0 && k < 20) begin tick(); k++; end
    while (rif.resetN === 1'b0 && lo < 100) begin
      if (deviceReady === 1'b0) dn = 1'b1;
      tick();
      lo++;
    end
    chk("reset pulse long enough", 1'h1, lo >= 10);
    for (k = 0; k < 300 && (r < 0 || b < 0); k++) begin
      // readiness counts only once the pulse has taken the flash out of ready
      if (deviceReady === 1'b0) dn = 1'b1;
      if (r < 0 && dn && deviceReady === 1'b1) r = k;
      if (b < 0 && busy === 1'b0) b = k;
      tick();
    end
    if (c == rescue_pkg::OP_IDLE) chk("ready within 40 ns", 1'h1, r >= 0 && r <= 8);
    else chk("ready within array recovery", 1'h1, r >= 0 && r <= ARR + 5);
    chk("host wait after reset", 1'h1, b >= host_wait(c) - 1 && b <= host_wait(c) + 4);
    $display("test reset pin cause %0d done", c);
  endtask

  task automatic run_rescue(input rescue_pkg::protocol_type p);
    int t = 0;
    frames.delete();
    cmdSeen = 1'b0;
    @(posedge mclk) rescueStart <= 1'b1;
    @(posedge mclk) rescueStart <= 1'b0;
    #1;
    chk("busy after start", 1'h1, busy);
    chk("hint cleared", 1'h0, rewriteNvHint);
    while (rescueDone !== 1'b1 && t < 1000) begin
      // a start while busy must be ignored
      @(posedge mclk);
      rescueStart <= (t == 30);
      #1;
      t++;
    end
    chk("rescue length", 1'h1, t >= rescue_cycles() - 4 && t <= rescue_cycles() + 4);
    chk("frame count", 4, frames.size());
    for (int i = 0; i < 4; i++) chk("frame clocks", frame_len(i), frames[i]);
    chk("ones on lines", 0, onesBad);
    chk("execute in place off", 1'h0, xipActive);
    chk("protocol", rescue_pkg::PROTO_EXT, protocol);
    chk("command accepted", p == rescue_pkg::PROTO_EXT, cmdSeen);
    tick();
    chk("hint set", 1'h1, rewriteNvHint);
    chk("busy released", 1'h0, busy);
  endtask

  initial begin
    int w = 0;
    logic [31:0] c;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    while ((poweredUp !== 1'b1 || deviceReady !== 1'b1) && w < 200) begin tick(); w++; end
    chk("power wait", 1'h1, w >= PUC - 2 && w <= PUC + 4);
    $display("test power wait done");
    for (int i = 0; i < 6; i++) begin
      c = (i < 4) ? i : xorshift() % 4;
      repeat (1 + xorshift() % 8) @(posedge mclk);
      nvProtocol <= rescue_pkg::protocol_type'(i % 3);
      nvXip <= (i >= 3);
      pulse_reset(rescue_pkg::op_kind_type'(c[1:0]));
      chk("xip loaded", nvXip, xipActive);
      chk("protocol loaded", nvProtocol, protocol);
      run_rescue(nvProtocol);
      $display("test rescue %0d done", i);
    end
    reportAndStop();
  end

  initial begin
    repeat (12000) @(posedge mclk);
    nMismatch++;
    $display("unexpected timeout expected 0 seen 1");
    reportAndStop();
  end
endmodule
